// >>> shared/bstl_pkg.sv
/*
 * Shared definitions of the boundary-scan test logic: controller states,
 * instruction codes, boundary register layout and the pin carrier types.
 * Assumes one system clock that oversamples the test clock pin.
 */
`default_nettype none

package bstl_pkg;

    // ==========================================================
    // Controller states
    typedef enum logic [15:0] {
        ST_TEST_RESET = 16'h0001,
        ST_RUN_IDLE   = 16'h0002,
        ST_SEL_DR     = 16'h0004,
        ST_CAP_DR     = 16'h0008,
        ST_SHIFT_DR   = 16'h0010,
        ST_EXIT1_DR   = 16'h0020,
        ST_PAUSE_DR   = 16'h0040,
        ST_EXIT2_DR   = 16'h0080,
        ST_UPD_DR     = 16'h0100,
        ST_SEL_IR     = 16'h0200,
        ST_CAP_IR     = 16'h0400,
        ST_SHIFT_IR   = 16'h0800,
        ST_EXIT1_IR   = 16'h1000,
        ST_PAUSE_IR   = 16'h2000,
        ST_EXIT2_IR   = 16'h4000,
        ST_UPD_IR     = 16'h8000
    } bstl_state_t;

    // ==========================================================
    // Instructions
    localparam int unsigned IR_W = 3;
    typedef logic [IR_W-1:0] bstl_instr_t;

    localparam bstl_instr_t INS_EXTEST    = 3'h0;
    localparam bstl_instr_t INS_SAMPLE    = 3'h1;
    localparam bstl_instr_t INS_USER1     = 3'h2;
    localparam bstl_instr_t INS_USER2     = 3'h3;
    localparam bstl_instr_t INS_READBACK  = 3'h4;
    localparam bstl_instr_t INS_CONFIGURE = 3'h5;
    localparam bstl_instr_t INS_RESERVED  = 3'h6;
    localparam bstl_instr_t INS_BYPASS    = 3'h7;

    // Fixed pattern captured into the instruction shifter
    localparam bstl_instr_t IR_CAPTURE_VAL = 3'h1;
    localparam bstl_instr_t IR_RESET_VAL   = INS_BYPASS;

    // ==========================================================
    // Boundary register layout
    localparam int unsigned BSR_TDO_T_POS = 0;
    localparam int unsigned BSR_TDO_I_POS = 1;
    localparam int unsigned BSR_IOB_BASE  = 2;
    localparam int unsigned CELL_IN_OFS   = 0;
    localparam int unsigned CELL_OUT_OFS  = 1;
    localparam int unsigned CELL_OE_OFS   = 2;
    localparam int unsigned CELLS_PER_IOB = 3;
    localparam int unsigned BSR_SPECIAL_CNT = 3;

    localparam int unsigned DEF_IOBS     = 4;
    localparam int unsigned DEF_IN_PINS  = 1;
    localparam int unsigned DEF_OUT_PINS = 1;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bstl_tap_t;

    typedef struct packed {
        logic out;
        logic oe;
    } bstl_drive_t;

endpackage

`default_nettype wire

// >>> hdl/bstl_tap_fsm.sv
/*
 * Sixteen-state test-port controller, stepped on each sampled rising
 * test clock edge. Assumes rise_i and tms_i come from synchronised pins.
 */
`default_nettype none

module bstl_tap_fsm (
    // Clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 rst_i,
    // Stepping
    input  wire logic                 hold_reset_i,
    input  wire logic                 rise_i,
    input  wire logic                 tms_i,
    // State
    output bstl_pkg::bstl_state_t     state_o
);
    import bstl_pkg::*;

    bstl_state_t state_q;
    bstl_state_t state_d;

    // ==========================================================
    // Next state
    always_comb begin
        state_d = state_q;
        if (hold_reset_i) begin
            state_d = ST_TEST_RESET;
        end else if (rise_i) begin // [RULE22]
            unique case (state_q) // [RULE4]
                ST_TEST_RESET: state_d = tms_i ? ST_TEST_RESET : ST_RUN_IDLE;
                ST_RUN_IDLE:   state_d = tms_i ? ST_SEL_DR : ST_RUN_IDLE;
                ST_SEL_DR:     state_d = tms_i ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR:     state_d = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR:   state_d = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_EXIT1_DR:   state_d = tms_i ? ST_UPD_DR : ST_PAUSE_DR;
                ST_PAUSE_DR:   state_d = tms_i ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR:   state_d = tms_i ? ST_UPD_DR : ST_SHIFT_DR;
                ST_UPD_DR:     state_d = tms_i ? ST_SEL_DR : ST_RUN_IDLE;
                ST_SEL_IR:     state_d = tms_i ? ST_TEST_RESET : ST_CAP_IR;
                ST_CAP_IR:     state_d = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_SHIFT_IR:   state_d = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_EXIT1_IR:   state_d = tms_i ? ST_UPD_IR : ST_PAUSE_IR;
                ST_PAUSE_IR:   state_d = tms_i ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR:   state_d = tms_i ? ST_UPD_IR : ST_SHIFT_IR;
                ST_UPD_IR:     state_d = tms_i ? ST_SEL_DR : ST_RUN_IDLE;
                default:       state_d = ST_TEST_RESET;
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q <= ST_TEST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign state_o = state_q;

endmodule

`default_nettype wire

// >>> hdl/bstl_top.sv
/*
 * Boundary-scan test logic: pin sync, registers, output and pin control.
 * Assumes tck is much slower than mclk_i (4+ cycles per half period)
 * and that user and configuration nets run on mclk_i.
 */
// Overview of operation
// [RULE1] Bypass, sample/preload and external test follow the standard.
// [RULE2] Scan enabled: three user pins become test inputs.
// [RULE3] No test reset pin; mode input held high resets.
// [RULE4] Sixteen-state controller, instruction and selected data registers.
// [RULE5] Capture loads the selected register; shift moves bits out and in.
// [RULE6] Update copies shifted bits to latches; waits allowed before.
// [RULE7] Each I/O block: three shift and three update cells.
// [RULE8] Other pins have only an input or an output cell.
// [RULE9] External-test capture samples every input pin.
// [RULE10] Bypass is one flip-flop retimed to the test clock.
// [RULE11] Two user select nets, decoded from the user instructions.
// [RULE12] A user instruction routes its return net to test data out.
// [RULE13] Data-register shift clock is an internal net.
// [RULE14] Idle net is NAND of test clock and run-idle.
// [RULE15] 000 external test drives pins; 001 sample keeps normal pins.
// [RULE16] 010, 011 user returns; 100 readback; pins stay normal.
// [RULE17] 101 configures: configuration serial out, pins disabled.
// [RULE18] 111 bypass, normal pins; 110 reserved, never loaded (the logic loads 110 like any code and treats it as bypass).
// [RULE19] Block cells ordered input, output, enable.
// [RULE20] Output enable and data at bits 0 and 1; special bit last.
// [RULE21] Program, configuration clock and done pins have no cells.
// [RULE22] Controller steps on rising test clock; output changes on falling.
`default_nettype none

module bstl_top #(
    parameter int unsigned N_IOB = bstl_pkg::DEF_IOBS,
    parameter int unsigned N_IN  = bstl_pkg::DEF_IN_PINS,
    parameter int unsigned N_OUT = bstl_pkg::DEF_OUT_PINS
) (
    // Clock and reset
    input  wire logic                      mclk_i,
    input  wire logic                      rst_i,
    // Scan option strap and the three shared pins
    input  wire logic                      bscan_en_i,
    input  wire bstl_pkg::bstl_tap_t       tap_pins_i,
    input  wire bstl_pkg::bstl_tap_t       core_shared_out_i,
    input  wire bstl_pkg::bstl_tap_t       core_shared_oe_i,
    output bstl_pkg::bstl_tap_t            shared_pin_out_o,
    output bstl_pkg::bstl_tap_t            shared_pin_oe_o,
    output bstl_pkg::bstl_tap_t            core_shared_in_o,
    // Test data out pin
    output logic                           tdo_o,
    output logic                           tdo_oe_o,
    // I/O block pins
    input  wire logic [N_IOB-1:0]          iob_pin_in_i,
    input  wire bstl_pkg::bstl_drive_t [N_IOB-1:0] core_iob_i,
    output bstl_pkg::bstl_drive_t [N_IOB-1:0]      iob_pin_o,
    output logic [N_IOB-1:0]               core_iob_in_o,
    // Input-only and output-only pins
    input  wire logic [N_IN-1:0]           inp_pin_i,
    output logic [N_IN-1:0]                core_inp_o,
    input  wire logic [N_OUT-1:0]          core_outp_i,
    output logic [N_OUT-1:0]               outp_pin_o,
    // User test logic nets
    output logic                           user_instr_one_select_o,
    output logic                           user_instr_two_select_o,
    input  wire logic                      user_one_serial_return_i,
    input  wire logic                      user_two_serial_return_i,
    output logic                           user_serial_in_o,
    output logic                           data_reg_shift_clock_o,
    output logic                           run_idle_gated_clock_o,
    // Configuration nets
    input  wire logic                      readback_data_i,
    input  wire logic                      config_serial_out_i,
    output logic                           readback_select_o,
    output logic                           config_select_o,
    // Special test latch
    output logic                           special_update_test_bit_o
);
    import bstl_pkg::*;

    localparam int unsigned IN_BASE  = BSR_IOB_BASE + CELLS_PER_IOB * N_IOB;
    localparam int unsigned OUT_BASE = IN_BASE + N_IN;
    localparam int unsigned BSR_LEN  = OUT_BASE + N_OUT + 1;
    localparam int unsigned UPD_POS  = BSR_LEN - 1;

    // ==========================================================
    // Parameter check
    if (N_IOB < 1 || N_IN < 1 || N_OUT < 1) begin : g_bad_params
        $error("bstl_top: pin counts must be at least one");
    end

    // ==========================================================
    // Decode helpers
    function automatic logic uses_bsr(input bstl_instr_t ins);
        return (ins == INS_EXTEST) || (ins == INS_SAMPLE); // [RULE1]
    endfunction

    function automatic logic pins_from_bsr(input bstl_instr_t ins);
        return ins == INS_EXTEST; // [RULE15]
    endfunction

    function automatic logic pins_off(input bstl_instr_t ins);
        return ins == INS_CONFIGURE; // [RULE17]
    endfunction

    // ==========================================================
    // Pin synchronisers
    bstl_tap_t          tap_s1_q;
    bstl_tap_t          tap_s2_q;
    logic               tck_s3_q;
    logic               en_s1_q;
    logic               en_s2_q;
    logic [N_IOB-1:0]   iob_s1_q;
    logic [N_IOB-1:0]   iob_s2_q;
    logic [N_IN-1:0]    inp_s1_q;
    logic [N_IN-1:0]    inp_s2_q;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tap_s1_q <= '0;
            tap_s2_q <= '0;
            tck_s3_q <= 1'b0;
            en_s1_q  <= 1'b0;
            en_s2_q  <= 1'b0;
            iob_s1_q <= '0;
            iob_s2_q <= '0;
            inp_s1_q <= '0;
            inp_s2_q <= '0;
        end else begin
            tap_s1_q <= tap_pins_i;
            tap_s2_q <= tap_s1_q;
            tck_s3_q <= tap_s2_q.tck;
            en_s1_q  <= bscan_en_i;
            en_s2_q  <= en_s1_q;
            iob_s1_q <= iob_pin_in_i;
            iob_s2_q <= iob_s1_q;
            inp_s1_q <= inp_pin_i;
            inp_s2_q <= inp_s1_q;
        end
    end

    logic tck_rise;
    logic tck_fall;
    assign tck_rise = tap_s2_q.tck & ~tck_s3_q;
    assign tck_fall = ~tap_s2_q.tck & tck_s3_q;

    // ==========================================================
    // Controller
    bstl_state_t state;

    // With the option off the pins belong to the user and the
    // controller is parked; with it on, only the mode input can reset it.
    bstl_tap_fsm u_fsm (
        .mclk_i       (mclk_i),
        .rst_i        (rst_i),
        .hold_reset_i (~en_s2_q), // [RULE2] [RULE3]
        .rise_i       (tck_rise),
        .tms_i        (tap_s2_q.tms),
        .state_o      (state)
    );

    // ==========================================================
    // Shift registers and latches
    bstl_instr_t         ir_sr_q, ir_sr_d;
    bstl_instr_t         ir_q, ir_d;
    logic [BSR_LEN-1:0]  bsr_sr_q, bsr_sr_d;
    logic [BSR_LEN-1:0]  bsr_upd_q, bsr_upd_d;
    logic [BSR_LEN-1:0]  cap_vec;
    logic                byp_q, byp_d;
    logic                tdo_d;
    logic                tdo_oe_d;
    logic                tdi;

    assign tdi = tap_s2_q.tdi;

    // Capture vector; program, config clock and done have no cells
    assign cap_vec[BSR_TDO_T_POS] = 1'b0; // [RULE20] [RULE21]
    assign cap_vec[BSR_TDO_I_POS] = 1'b0; // [RULE20]
    assign cap_vec[UPD_POS]       = bsr_upd_q[UPD_POS]; // [RULE20]

    for (genvar k = 0; k < N_IOB; k++) begin : g_iob_cap
        localparam int unsigned P = BSR_IOB_BASE + CELLS_PER_IOB * k;
        // Under external test the out cells see what the latches drive
        assign cap_vec[P + CELL_IN_OFS] = iob_s2_q[k]; // [RULE7] [RULE9] [RULE19]
        assign cap_vec[P + CELL_OUT_OFS] = pins_from_bsr(ir_q) ?
            bsr_upd_q[P + CELL_OUT_OFS] : core_iob_i[k].out; // [RULE7] [RULE19]
        assign cap_vec[P + CELL_OE_OFS] = pins_from_bsr(ir_q) ?
            bsr_upd_q[P + CELL_OE_OFS] : core_iob_i[k].oe; // [RULE7] [RULE19]
    end

    for (genvar i = 0; i < N_IN; i++) begin : g_in_cap
        assign cap_vec[IN_BASE + i] = inp_s2_q[i]; // [RULE8] [RULE9]
    end

    for (genvar j = 0; j < N_OUT; j++) begin : g_out_cap
        assign cap_vec[OUT_BASE + j] = pins_from_bsr(ir_q) ?
            bsr_upd_q[OUT_BASE + j] : core_outp_i[j]; // [RULE8]
    end

    // Serial source for the test data output
    logic dr_src;
    always_comb begin
        unique case (ir_q)
            INS_EXTEST, INS_SAMPLE: dr_src = bsr_sr_q[0]; // [RULE15]
            INS_USER1:     dr_src = user_one_serial_return_i; // [RULE12] [RULE16]
            INS_USER2:     dr_src = user_two_serial_return_i; // [RULE12] [RULE16]
            INS_READBACK:  dr_src = readback_data_i; // [RULE16]
            INS_CONFIGURE: dr_src = config_serial_out_i; // [RULE17]
            INS_RESERVED, INS_BYPASS: dr_src = byp_q; // [RULE18]
        endcase
    end

    always_comb begin
        ir_sr_d   = ir_sr_q;
        ir_d      = ir_q;
        bsr_sr_d  = bsr_sr_q;
        bsr_upd_d = bsr_upd_q;
        byp_d     = byp_q;
        tdo_d     = tdo_o;
        tdo_oe_d  = tdo_oe_o;
        if (tck_rise) begin
            unique case (state)
                ST_CAP_IR:   ir_sr_d = IR_CAPTURE_VAL; // [RULE5]
                ST_SHIFT_IR: ir_sr_d = {tdi, ir_sr_q[IR_W-1:1]}; // [RULE5]
                ST_CAP_DR: begin
                    if (uses_bsr(ir_q)) begin
                        bsr_sr_d = cap_vec; // [RULE5] [RULE9]
                    end
                    byp_d = 1'b0; // [RULE10]
                end
                ST_SHIFT_DR: begin
                    if (uses_bsr(ir_q)) begin
                        bsr_sr_d = {tdi, bsr_sr_q[BSR_LEN-1:1]}; // [RULE5]
                    end
                    byp_d = tdi; // [RULE10]
                end
                default: ;
            endcase
        end
        // Falling edge: the state has already stepped on the rising one
        if (tck_fall) begin
            tdo_d    = (state == ST_SHIFT_IR) ? ir_sr_q[0] : dr_src; // [RULE22]
            tdo_oe_d = (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);
            if (state == ST_UPD_IR) begin
                ir_d = ir_sr_q; // [RULE6]
            end
            if (state == ST_UPD_DR && uses_bsr(ir_q)) begin
                bsr_upd_d = bsr_sr_q; // [RULE6] [RULE1]
            end
        end
        if (state == ST_TEST_RESET) begin
            ir_d     = IR_RESET_VAL; // [RULE3]
            tdo_oe_d = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ir_sr_q   <= '0;
            ir_q      <= IR_RESET_VAL;
            bsr_sr_q  <= '0;
            bsr_upd_q <= '0;
            byp_q     <= 1'b0;
            tdo_o     <= 1'b0;
            tdo_oe_o  <= 1'b0;
        end else begin
            ir_sr_q   <= ir_sr_d;
            ir_q      <= ir_d;
            bsr_sr_q  <= bsr_sr_d;
            bsr_upd_q <= bsr_upd_d;
            byp_q     <= byp_d;
            tdo_o     <= tdo_d;
            tdo_oe_o  <= tdo_oe_d;
        end
    end

    // ==========================================================
    // Pin control
    bstl_drive_t [N_IOB-1:0] iob_d;
    logic [N_OUT-1:0]        outp_d;

    for (genvar k = 0; k < N_IOB; k++) begin : g_iob_drv
        localparam int unsigned P = BSR_IOB_BASE + CELLS_PER_IOB * k;
        assign iob_d[k] = pins_off(ir_q) ? '0 : // [RULE17]
            pins_from_bsr(ir_q) ?
            {bsr_upd_q[P + CELL_OUT_OFS], bsr_upd_q[P + CELL_OE_OFS]} : // [RULE15]
            core_iob_i[k]; // [RULE16] [RULE18]
    end

    for (genvar j = 0; j < N_OUT; j++) begin : g_out_drv
        assign outp_d[j] = pins_off(ir_q) ? 1'b0 :
            pins_from_bsr(ir_q) ? bsr_upd_q[OUT_BASE + j] : core_outp_i[j]; // [RULE15]
    end

    // ==========================================================
    // User, configuration and shared pin nets
    logic  sel1_d, sel2_d, rb_d, cfg_d, drck_d, idle_d;
    logic  state_cap_shift;

    assign state_cap_shift = (state == ST_CAP_DR) || (state == ST_SHIFT_DR);

    always_comb begin
        sel1_d = (ir_q == INS_USER1); // [RULE11]
        sel2_d = (ir_q == INS_USER2); // [RULE11]
        rb_d   = (ir_q == INS_READBACK);
        cfg_d  = (ir_q == INS_CONFIGURE);
        drck_d = tap_s2_q.tck & state_cap_shift; // [RULE13]
        idle_d = ~(tap_s2_q.tck & (state == ST_RUN_IDLE)); // [RULE14]
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            iob_pin_o                 <= '0;
            outp_pin_o                <= '0;
            core_iob_in_o             <= '0;
            core_inp_o                <= '0;
            shared_pin_out_o          <= '0;
            shared_pin_oe_o           <= '0;
            core_shared_in_o          <= '0;
            user_instr_one_select_o   <= 1'b0;
            user_instr_two_select_o   <= 1'b0;
            user_serial_in_o          <= 1'b0;
            data_reg_shift_clock_o    <= 1'b0;
            run_idle_gated_clock_o    <= 1'b1;
            readback_select_o         <= 1'b0;
            config_select_o           <= 1'b0;
            special_update_test_bit_o <= 1'b0;
        end else begin
            iob_pin_o                 <= iob_d;
            outp_pin_o                <= outp_d;
            core_iob_in_o             <= iob_s2_q;
            core_inp_o                <= inp_s2_q;
            // Dedicated test inputs are never driven while the option is on
            shared_pin_out_o          <= core_shared_out_i;
            shared_pin_oe_o           <= en_s2_q ? '0 : core_shared_oe_i; // [RULE2]
            core_shared_in_o          <= en_s2_q ? '0 : tap_s2_q; // [RULE2]
            user_instr_one_select_o   <= sel1_d;
            user_instr_two_select_o   <= sel2_d;
            user_serial_in_o          <= tdi;
            data_reg_shift_clock_o    <= drck_d;
            run_idle_gated_clock_o    <= idle_d;
            readback_select_o         <= rb_d;
            config_select_o           <= cfg_d;
            special_update_test_bit_o <= bsr_upd_q[UPD_POS]; // [RULE20]
        end
    end

endmodule

`default_nettype wire

// >>> dv/bstl_tap_model.sv
/* Board test controller model that drives the test port pins.
   Assumes the bench calls its tasks one at a time, between frames. */
`default_nettype none
module bstl_tap_model (
    // Test port
    output var bstl_pkg::bstl_tap_t tap_o,
    input  wire logic               tdo_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import bstl_pkg::*;
    initial tap_o = '0;
    // ========
    // One test clock; tck stands low outside frames
    task automatic clk(input logic tms, input logic tdi, output logic tdo);
        tap_o.tms = tms;
        tap_o.tdi = tdi;
        #24;
        tdo = tdo_i;
        tap_o.tck = 1'b1;
        #24;
        tap_o.tck = 1'b0;
    endtask
    // ========
    // No reset pin, so five clocks with mode high reach reset
    task automatic reset_tap();
        logic d;
        repeat (5) clk(1'b1, 1'b0, d);
        clk(1'b0, 1'b0, d);
    endtask
    // ========
    // Scan from run-idle and return there; bit 0 leaves first
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic d;
        dout = '0;
        if (ir && din[2:0] == INS_RESERVED) return;
        clk(1'b1, 1'b0, d);
        if (ir) clk(1'b1, 1'b0, d);
        repeat (2) clk(1'b0, 1'b0, d);
        for (int i = 0; i < n; i++) begin
            clk(i == n - 1, din[i], d);
            dout[i] = d;
        end
        clk(1'b1, 1'b0, d);
        clk(1'b0, 1'b0, d);
        // Idle data line shows the inverse
        tap_o.tdi = ~din[n-1];
    endtask
endmodule
`default_nettype wire

// >>> dv/bstl_checker.sv
/* Port checker for the boundary-scan test logic, bound into bstl_top.
   Assumes the single mclk_i domain with synchronous rst_i. */
`default_nettype none
module bstl_checker #(
    parameter int unsigned N_IOB = 4
) (
    input wire logic                                mclk_i,
    input wire logic                                rst_i,
    input wire logic                                bscan_en_i,
    input wire bstl_pkg::bstl_tap_t                 tap_pins_i,
    input wire bstl_pkg::bstl_tap_t                 shared_pin_oe_o,
    input wire logic                                tdo_oe_o,
    input wire logic [N_IOB-1:0]                    iob_pin_in_i,
    input wire logic [N_IOB-1:0]                    core_iob_in_o,
    input wire bstl_pkg::bstl_drive_t [N_IOB-1:0]   core_iob_i,
    input wire bstl_pkg::bstl_drive_t [N_IOB-1:0]   iob_pin_o,
    input wire logic                                user_instr_one_select_o,
    input wire logic                                user_instr_two_select_o,
    input wire logic                                data_reg_shift_clock_o,
    input wire logic                                run_idle_gated_clock_o,
    input wire logic                                readback_select_o,
    input wire logic                                config_select_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // ========
    // Assertions
    a_sel_exclusive: assert property (user_instr_one_select_o |->
        !(user_instr_two_select_o || readback_select_o || config_select_o))
        else $error("selects overlap");
    a_strap_takes_pins: assert property (bscan_en_i [*6] |=>
        shared_pin_oe_o == 3'h0) else $error("shared pin driven");
    a_strap_off_idle: assert property (!bscan_en_i [*6] |=>
        !tdo_oe_o && !user_instr_one_select_o && !config_select_o)
        else $error("active with scan off");
    a_idle_net_high: assert property (!tap_pins_i.tck [*5] |=>
        run_idle_gated_clock_o) else $error("idle net low");
    a_drck_low: assert property (!tap_pins_i.tck [*5] |=>
        !data_reg_shift_clock_o) else $error("shift clock high");
    a_config_pads_off: assert property (config_select_o [*2] |->
        iob_pin_o == '0) else $error("pads driven in configure");
    a_user_pads_normal: assert property ((user_instr_one_select_o ||
        readback_select_o) [*2] |-> iob_pin_o == $past(core_iob_i))
        else $error("pads not from core");
    a_core_sees_pins: assert property ((!config_select_o &&
        $stable(iob_pin_in_i)) [*4] |=> core_iob_in_o == iob_pin_in_i)
        else $error("core input stale");
    c_user_two: cover property (user_instr_two_select_o);
    c_config: cover property (config_select_o [*2]);
    c_drck: cover property (data_reg_shift_clock_o);
endmodule
bind bstl_top bstl_checker #(.N_IOB(N_IOB)) bstl_checker_i (.*);
`default_nettype wire

// >>> dv/bstl_top_tb.sv
/* Bench: strap, bypass, user and configuration routing, boundary register.
   Assumes the tester model. */
`default_nettype none
module bstl_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bstl_pkg::*;
    localparam int BL = 17;
    logic       mclk = 1'b0, rst = 1'b1, en = 1'b0, r1 = 1'b0, r2 = 1'b0, rbd = 1'b0;
    logic       cfo = 1'b0, tdo, tdo_oe, s1, s2, rbs, cfs, spec;
    logic [3:0] pin_in = 4'h0;
    logic [0:0] inp = 1'b0, coutp = 1'b0, outp;
    bstl_tap_t  tap, sh_oe, sh_in, sh_out;
    bstl_drive_t [3:0] core_iob = 8'h0, pads;
    int         bad_count = 0, cmp_count = 0, cyc = 0;
    always #2 mclk = ~mclk;
    bstl_top bstl_top_i (.mclk_i(mclk), .rst_i(rst), .bscan_en_i(en), .tap_pins_i(tap),
        .core_shared_out_i(3'h3), .core_shared_oe_i(3'h5), .shared_pin_out_o(sh_out),
        .shared_pin_oe_o(sh_oe), .core_shared_in_o(sh_in), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .iob_pin_in_i(pin_in), .core_iob_i(core_iob), .iob_pin_o(pads), .core_iob_in_o(),
        .inp_pin_i(inp), .core_inp_o(), .core_outp_i(coutp), .outp_pin_o(outp),
        .user_instr_one_select_o(s1), .user_instr_two_select_o(s2),
        .user_one_serial_return_i(r1), .user_two_serial_return_i(r2),
        .user_serial_in_o(), .data_reg_shift_clock_o(), .run_idle_gated_clock_o(),
        .readback_data_i(rbd), .config_serial_out_i(cfo), .readback_select_o(rbs),
        .config_select_o(cfs), .special_update_test_bit_o(spec));
    bstl_tap_model tap_i (.tap_o(tap), .tdo_i(tdo));
    // ========
    // Checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    // ========
    // Scenarios
    task automatic t_strap();
        repeat (10) @(negedge mclk);
        chk(sh_oe, 3'h5);
        chk(sh_out, 3'h3);
        chk(tdo_oe, 1'b0);
        en = 1'b1;
        repeat (10) @(negedge mclk);
        chk({sh_oe, sh_in}, 6'h0);
    endtask
    task automatic t_bypass();
        logic [31:0] d;
        tap_i.reset_tap();
        tap_i.scan(1'b1, 3, INS_BYPASS, d);
        chk(d, IR_CAPTURE_VAL);
        tap_i.scan(1'b0, 4, 32'hf, d);
        chk(d, 4'he);
    endtask
    task automatic t_user();
        logic [31:0] d;
        logic [3:0]  src;
        for (int c = 2; c <= 5; c++) begin
            src = 4'h1 << (c - 2);
            @(negedge mclk);
            {cfo, rbd, r2, r1} = src;
            core_iob = 8'h5a ^ 8'(c);
            tap_i.scan(1'b1, 3, c, d);
            chk({cfs, rbs, s2, s1}, src);
            chk(pads, (c == 5) ? 8'h0 : core_iob);
            tap_i.scan(1'b0, 2, 32'h0, d);
            chk(d, 2'h3);
        end
    endtask
    task automatic cap_exp(input logic lat, input logic [31:0] p, output logic [31:0] e);
        e = '0;
        for (int k = 0; k < 4; k++) begin
            e[2+3*k] = pin_in[k];
            e[3+3*k] = lat ? p[3+3*k] : core_iob[k].out;
            e[4+3*k] = lat ? p[4+3*k] : core_iob[k].oe;
        end
        e[15:14] = {lat ? p[15] : coutp[0], inp[0]};
        e[16] = p[16];
    endtask
    task automatic t_boundary();
        logic [31:0] d, p, e;
        p = 32'h0001_a5b6;
        @(negedge mclk);
        {pin_in, inp, coutp, core_iob} = {4'h9, 1'b1, 1'b1, 8'h6c};
        tap_i.scan(1'b1, 3, INS_SAMPLE, d);
        tap_i.scan(1'b0, BL, p, d);
        cap_exp(1'b0, 32'h0, e);
        chk(d, e);
        chk(pads, core_iob);
        tap_i.scan(1'b1, 3, INS_EXTEST, d);
        for (int k = 0; k < 4; k++) begin
            e[2*k+1] = p[3+3*k];
            e[2*k] = p[4+3*k];
        end
        chk({pads, outp, spec}, {e[7:0], p[15], p[16]});
        tap_i.scan(1'b0, BL, ~p, d);
        cap_exp(1'b1, p, e);
        chk(d, e);
    endtask
    initial begin
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        t_strap();
        t_bypass();
        t_user();
        t_boundary();
        end_of_test();
    end
endmodule
`default_nettype wire
